// ==== core/spimsp_port.sv ====
`timescale 1ns/10ps
module spimsp_port
(
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [31:0] addr_i,
    input  wire logic        wr_en_i,
    input  wire logic        rd_en_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] rdata_o,
    output logic             irq_o,
    input  wire logic        sclk_i,
    output logic             sclk_o,
    output logic             sclk_oe_o,
    input  wire logic        mosi_i,
    output logic             mosi_o,
    output logic             mosi_oe_o,
    input  wire logic        miso_i,
    output logic             miso_o,
    output logic             miso_oe_o,
    input  wire logic        cs_n_i,
    output logic             cs_n_o,
    output logic             cs_oe_o
);
    // =========================================================
    // Registers and state.
    logic [15:0] ctrl;
    logic [7:0]  div;
    logic [7:0]  rx;
    logic [7:0]  tx;
    logic [7:0]  last_tx;
    logic        tx_valid;
    logic        rx_full;
    logic        ovf;
    logic        uf;
    logic [7:0]  sr;
    logic [7:0]  rx_sr;
    logic [2:0]  bitcnt;
    logic        first;
    logic [7:0]  div_cnt;
    logic [3:0]  half;
    logic        sclk_int;
    logic        cs_hold;
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic [3:0]  s3;
    logic [3:0]  filt;
    spimsp_pkg::spimsp_state_t state;
    spimsp_pkg::spimsp_state_t next_state;

    // Control field decode.
    wire en     = ctrl[spimsp_pkg::B_EN];
    wire master = ctrl[spimsp_pkg::B_MASTER];
    wire cpha   = ctrl[spimsp_pkg::B_CPHA];
    wire cpol   = ctrl[spimsp_pkg::B_CPOL];
    wire lsb    = ctrl[spimsp_pkg::B_LSB];
    wire txmode = ctrl[spimsp_pkg::B_TXMODE];
    wire cont   = ctrl[spimsp_pkg::B_CONT];
    wire od     = ctrl[spimsp_pkg::B_OD];

    // Register access strobes.
    wire wr_tx   = wr_en_i && (addr_i == spimsp_pkg::ADDR_TX);
    wire wr_div  = wr_en_i && (addr_i == spimsp_pkg::ADDR_DIV);
    wire wr_ctrl = wr_en_i && (addr_i == spimsp_pkg::ADDR_CTRL);
    wire rd_rx   = rd_en_i && (addr_i == spimsp_pkg::ADDR_RX);

    // =========================================================
    // Pin synchronisers; bit 0 sclk, 1 mosi, 2 miso, 3 cs_n.
    wire [3:0] pins   = {cs_n_i, miso_i, mosi_i, sclk_i};
    wire [3:0] agree  = ~(s2 ^ s3);
    wire [3:0] chg    = agree & (s3 ^ filt);
    wire       slave  = en && !master;
    wire       s_sel  = slave && !filt[3];
    wire       s_chg  = s_sel && chg[0];
    wire       cs_fall = slave && chg[3] && !s3[3];

    // Master half-period divider and transfer sequencing.
    wire tick     = (state != spimsp_pkg::ST_IDLE) && (div_cnt == div);
    wire m_run    = (state == spimsp_pkg::ST_RUN) && tick;
    wire m_lead   = m_run && (sclk_int == cpol);
    wire m_trail  = m_run && (sclk_int != cpol);
    wire m_end    = m_trail && (half == spimsp_pkg::HALF_LAST);
    wire go_on    = cont && tx_valid;
    wire start_go = txmode ? tx_valid : rd_rx;
    wire start_req = en && master && (state == spimsp_pkg::ST_IDLE) && start_go;

    // Edge classification shared by both roles.
    wire s_lead   = s_chg && (s3[0] != cpol);
    wire s_trail  = s_chg && (s3[0] == cpol);
    wire lead     = master ? m_lead : s_lead;
    wire trail    = master ? m_trail : s_trail;
    wire sample_ev = cpha ? trail : lead;
    wire shift_ev  = cpha ? lead : trail;
    wire byte_done = sample_ev && (bitcnt == spimsp_pkg::BIT_LAST);
    wire s_reload  = byte_done && !master;
    wire m_reload  = m_end && go_on;
    wire load      = start_req || cs_fall || s_reload || m_reload;

    // Data paths.
    wire       out_bit = lsb ? sr[0] : sr[7];
    wire       pin_in  = master ? filt[2] : filt[1];
    wire       in_bit  = ctrl[spimsp_pkg::B_LOOP] ? out_bit : pin_in;
    wire [7:0] rx_next = lsb ? {in_bit, rx_sr[7:1]} : {rx_sr[6:0], in_bit};
    wire [7:0] sr_next = lsb ? {1'b0, sr[7:1]} : {sr[6:0], 1'b0};
    wire [7:0] uf_data = ctrl[spimsp_pkg::B_UFZERO] ? spimsp_pkg::ZERO_BYTE : last_tx;
    wire [7:0] ld_data = tx_valid ? tx : uf_data;
    wire       uf_set  = load && !tx_valid;
    wire       rx_take = byte_done && (!rx_full || ctrl[spimsp_pkg::B_OVWR]);

    // Status image.
    wire [7:0] status = {2'b00, ovf, rx_full || ovf, rx_full, uf, !tx_valid || uf, tx_valid};
    wire       irq_sel = txmode ? status[spimsp_pkg::S_TXIRQ] : status[spimsp_pkg::S_RXIRQ];

    // Read data selection; unmapped and write-only addresses read zero.
    logic [15:0] next_rdata;
    always_comb
    begin
        unique case (addr_i)
            spimsp_pkg::ADDR_STATUS: next_rdata = {8'h00, status};
            spimsp_pkg::ADDR_RX:     next_rdata = {8'h00, rx};
            spimsp_pkg::ADDR_DIV:    next_rdata = {8'h00, div};
            spimsp_pkg::ADDR_CTRL:   next_rdata = ctrl;
            default:                 next_rdata = 16'h0000;
        endcase
    end

    // Master sequencer next state; a disabled port stays idle.
    always_comb
    begin
        next_state = state;
        unique case (state)
            spimsp_pkg::ST_IDLE:
                if (start_req)
                    next_state = spimsp_pkg::ST_RUN;
            spimsp_pkg::ST_RUN:
                if (m_end && !go_on)
                    next_state = cont ? spimsp_pkg::ST_IDLE : spimsp_pkg::ST_STALL;
            spimsp_pkg::ST_STALL:
                if (tick && (half == spimsp_pkg::STALL_LAST))
                    next_state = spimsp_pkg::ST_IDLE;
            default:
                next_state = spimsp_pkg::ST_IDLE;
        endcase
        if (!en || !master)
            next_state = spimsp_pkg::ST_IDLE;
    end

    // =========================================================
    // Software-visible registers.
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            ctrl    <= spimsp_pkg::CTRL_RESET;
            div     <= spimsp_pkg::DIV_RESET;
            tx      <= spimsp_pkg::TX_RESET;
            rx      <= spimsp_pkg::RX_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= wdata_i & spimsp_pkg::CTRL_MASK;
            if (wr_div)
                div <= wdata_i[7:0];
            if (wr_tx)
                tx <= wdata_i[7:0];
            if (rx_take)
                rx <= rx_next;
        end
    end

    // Sticky flags; a setting event wins over a same-cycle clear.
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            tx_valid <= 1'b0;
            rx_full  <= 1'b0;
            ovf      <= 1'b0;
            uf       <= 1'b0;
            last_tx  <= spimsp_pkg::TX_RESET;
        end
        else
        begin
            tx_valid <= wr_tx || (tx_valid && !load);
            rx_full  <= byte_done || (rx_full && !rd_rx);
            ovf      <= (byte_done && rx_full) || (ovf && !rd_rx);
            uf       <= uf_set || (uf && !wr_tx);
            if (load)
                last_tx <= ld_data;
        end
    end

    // Pin synchronisers and filtered levels.
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            s1   <= 4'h8;
            s2   <= 4'h8;
            s3   <= 4'h8;
            filt <= 4'h8;
        end
        else
        begin
            s1   <= pins;
            s2   <= s1;
            s3   <= s2;
            filt <= (agree & s3) | (~agree & filt);
        end
    end

    // Master clock generation; serial clock rests at the polarity level.
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            state    <= spimsp_pkg::ST_IDLE;
            div_cnt  <= 8'h00;
            half     <= 4'h0;
            sclk_int <= 1'b0;
            cs_hold  <= 1'b0;
        end
        else
        begin
            state   <= next_state;
            cs_hold <= m_end;
            div_cnt <= tick ? 8'h00 : 8'(div_cnt + 8'h01);
            if (next_state == spimsp_pkg::ST_IDLE || start_req || m_end)
            begin
                div_cnt <= 8'h00;
                half    <= 4'h0;
            end
            else if (tick)
                half <= 4'(half + 4'h1);
            if (state != spimsp_pkg::ST_RUN)
                sclk_int <= cpol;
            else if (tick)
                sclk_int <= ~sclk_int;
        end
    end

    // Shift engine shared by master and slave.
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            sr     <= 8'h00;
            rx_sr  <= 8'h00;
            bitcnt <= 3'h0;
            first  <= 1'b0;
        end
        else
        begin
            if (sample_ev)
            begin
                rx_sr  <= rx_next;
                bitcnt <= 3'(bitcnt + 3'h1);
            end
            if (start_req || cs_fall || m_end)
                bitcnt <= 3'h0;
            if (load)
            begin
                sr    <= ld_data;
                first <= s_reload ? 1'b1 : cpha;
            end
            else if (shift_ev && !m_end)
            begin
                if (first)
                    first <= 1'b0;
                else
                    sr <= sr_next;
            end
        end
    end

    // Registered pin and bus outputs.
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            rdata_o   <= 16'h0000;
            irq_o     <= 1'b0;
            sclk_o    <= 1'b0;
            sclk_oe_o <= 1'b0;
            mosi_o    <= 1'b0;
            mosi_oe_o <= 1'b0;
            miso_o    <= 1'b0;
            miso_oe_o <= 1'b0;
            cs_n_o    <= 1'b1;
            cs_oe_o   <= 1'b0;
        end
        else
        begin
            rdata_o   <= next_rdata;
            irq_o     <= en && irq_sel;
            sclk_o    <= sclk_int;
            sclk_oe_o <= en && master;
            mosi_o    <= out_bit;
            mosi_oe_o <= en && master;
            miso_o    <= od ? 1'b0 : out_bit;
            miso_oe_o <= s_sel && (!od || !out_bit);
            // Chip select outlasts the final clock edge by one cycle for slave hold time.
            cs_n_o    <= (state != spimsp_pkg::ST_RUN) && !cs_hold;
            cs_oe_o   <= en && master && !ctrl[spimsp_pkg::B_CSDIS];
        end
    end

    // =========================================================
    // Assertions.
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence seq_end_more;
        m_end && go_on;
    endsequence

    a_cont_keep_run: assert property (seq_end_more |=> (state == spimsp_pkg::ST_RUN) [*2])
        else $error("Continuous transfer dropped chip select.");
    a_single_stall: assert property (m_end && !cont |=> state == spimsp_pkg::ST_STALL)
        else $error("Single transfer skipped the stall.");
    a_loop_path: assert property (ctrl[spimsp_pkg::B_LOOP] && sample_ev |=> rx_sr[0] == $past(out_bit) || lsb)
        else $error("Loopback sample differs from output bit.");
    a_od_no_high: assert property (od && s_sel |=> !miso_o && (miso_oe_o == !$past(out_bit)))
        else $error("Open-drain output driven high.");
    a_cs_disable: assert property (ctrl[spimsp_pkg::B_CSDIS] |=> !cs_oe_o)
        else $error("Chip select driven while disabled.");
    a_rx_discard: assert property (byte_done && rx_full && !ctrl[spimsp_pkg::B_OVWR] |=> $stable(rx))
        else $error("Receive byte overwritten without permission.");
    a_uf_zero: assert property (uf_set && ctrl[spimsp_pkg::B_UFZERO] |=> sr == spimsp_pkg::ZERO_BYTE)
        else $error("Underflow did not send zeros.");
    a_tx_start: assert property (en && master && txmode && tx_valid && state == spimsp_pkg::ST_IDLE |=> state == spimsp_pkg::ST_RUN ##1 !cs_n_o)
        else $error("Transmit write did not start a transfer.");
    a_rx_clear: assert property (rd_rx && !byte_done |=> !rx_full && !ovf)
        else $error("Receive read did not clear flags.");
    a_idle_clock: assert property (!en [*2] |=> sclk_o == $past(cpol, 2))
        else $error("Disabled clock not at idle level.");
endmodule

// ==== core/spimsp_pkg.sv ====
package spimsp_pkg;
    // =========================================================
    // Register map.
    localparam logic [31:0] ADDR_STATUS = 32'hFFFF_0A00;
    localparam logic [31:0] ADDR_RX     = 32'hFFFF_0A04;
    localparam logic [31:0] ADDR_TX     = 32'hFFFF_0A08;
    localparam logic [31:0] ADDR_DIV    = 32'hFFFF_0A0C;
    localparam logic [31:0] ADDR_CTRL   = 32'hFFFF_0A10;
    // =========================================================
    // Reset values and writable control bits.
    localparam logic [7:0]  DIV_RESET  = 8'h1B;
    localparam logic [7:0]  RX_RESET   = 8'h00;
    localparam logic [7:0]  TX_RESET   = 8'h00;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_MASK  = 16'h1FEF;
    // =========================================================
    // Control bit positions.
    localparam int B_EN     = 0;
    localparam int B_MASTER = 1;
    localparam int B_CPHA   = 2;
    localparam int B_CPOL   = 3;
    localparam int B_LSB    = 5;
    localparam int B_TXMODE = 6;
    localparam int B_UFZERO = 7;
    localparam int B_OVWR   = 8;
    localparam int B_CSDIS  = 9;
    localparam int B_OD     = 10;
    localparam int B_LOOP   = 11;
    localparam int B_CONT   = 12;
    // =========================================================
    // Status bit positions.
    localparam int S_TXVAL  = 0;
    localparam int S_TXIRQ  = 1;
    localparam int S_UF     = 2;
    localparam int S_RXFULL = 3;
    localparam int S_RXIRQ  = 4;
    localparam int S_OVF    = 5;
    // =========================================================
    // Timing counts in half serial clock periods and bits.
    localparam logic [3:0] HALF_LAST  = 4'hF;
    localparam logic [3:0] STALL_LAST = 4'h1;
    localparam logic [2:0] BIT_LAST   = 3'h7;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RUN   = 2'b01,
        ST_STALL = 2'b11
    } spimsp_state_t;
endpackage

// ==== dv/spimsp_far_slave.sv ====
`timescale 1ns/10ps
// =====================================================================
// Far-side slave: captures each byte MSB first, replies with the inverse of the byte before it.
module spimsp_far_slave
(
    input  wire logic       sclk_i,
    input  wire logic       mosi_i,
    input  wire logic       cs_n_i,
    input  wire logic       cpol_i,
    input  wire logic       cpha_i,
    output logic            miso_o,
    output logic      [7:0] rx_o
);
    logic [7:0] shreg = 8'h00;
    logic [7:0] txb   = 8'hFF;
    int         cnt   = 0;

    initial rx_o = 8'h00;
    initial miso_o = 1'b0;

    // A frame start loads the reply; a released line shows the inverse of its last level.
    always @(cs_n_i)
    begin
        cnt = 0;
        txb = ~rx_o;
        miso_o = cs_n_i ? ~miso_o : txb[7];
    end

    // Phase 0 samples on the leading edge, phase 1 on the trailing one.
    always @(sclk_i)
    begin
        if (!cs_n_i)
        begin
            if ((sclk_i != cpol_i) != cpha_i)
            begin
                shreg = {shreg[6:0], mosi_i};
                cnt = cnt + 1;
                if (cnt == 8)
                begin
                    rx_o = shreg;
                    txb = ~shreg;
                    cnt = 0;
                end
            end
            else
                miso_o = txb[7 - cnt];
        end
    end
endmodule

// ==== dv/spi_master_slave_port_bench.sv ====
`timescale 1ns/10ps
// =====================================================================
// Bench: the port as master against the far-side slave, then as slave under the bench's far master.
module spi_master_slave_port_bench;
    typedef struct packed {logic [15:0] ctrl; logic [7:0] tx; logic [7:0] slv;} spimsp_row_t;
    localparam spimsp_row_t ROWS [8] = '{
        '{16'h0043, 8'hA5, 8'hA5}, '{16'h0047, 8'h3C, 8'h3C}, '{16'h004B, 8'h81, 8'h81},
        '{16'h004F, 8'h7E, 8'h7E}, '{16'h0063, 8'h01, 8'h80}, '{16'h0067, 8'hC8, 8'h13},
        '{16'h006B, 8'h96, 8'h69}, '{16'h006F, 8'h5F, 8'hFA}};
    logic        core_clk_i = 1'b0;
    logic        sys_rst_i  = 1'b1;
    logic [31:0] addr_i     = 32'h0000_0000;
    logic        wr_en_i    = 1'b0;
    logic        rd_en_i    = 1'b0;
    logic [15:0] wdata_i    = 16'h0000;
    logic [15:0] rdata_o;
    logic        irq_o, sclk_o, sclk_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
    logic        cs_n_o, cs_oe_o, far_miso, miso_line, cs_line, cs_q;
    logic        pol = 1'b0;
    logic        pha = 1'b0;
    logic [7:0]  slave_rx;
    logic [7:0]  prev = 8'h00;
    logic [15:0] got;
    logic        m_sclk = 1'b0;
    logic        m_mosi = 1'b0;
    logic        m_cs_n = 1'b1;
    logic [7:0]  m_got  = 8'h00;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          n_rise = 0;
    int          r0;
    int          base;

    // Clock at 100 MHz.
    always #5 core_clk_i = ~core_clk_i;

    // Released lines: chip select is pulled up, data follows whoever drives it.
    assign cs_line   = cs_oe_o ? cs_n_o : 1'b1;
    assign miso_line = miso_oe_o ? miso_o : far_miso;

    // Counts the ends of framed transfers.
    always @(posedge core_clk_i)
    begin
        cs_q <= cs_n_o;
        if (cs_n_o === 1'b1 && cs_q === 1'b0)
            n_rise <= n_rise + 1;
    end

    spimsp_port i_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .irq_o(irq_o), .sclk_i(m_sclk), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o),
        .mosi_i(m_mosi), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_line),
        .miso_o(miso_o), .miso_oe_o(miso_oe_o), .cs_n_i(m_cs_n), .cs_n_o(cs_n_o),
        .cs_oe_o(cs_oe_o));

    spimsp_far_slave i_far (.sclk_i(sclk_o), .mosi_i(mosi_o), .cs_n_i(cs_line),
        .cpol_i(pol), .cpha_i(pha), .miso_o(far_miso), .rx_o(slave_rx));

    function automatic logic [15:0] bitv(input int b);
        bitv = 16'h0001 << b;
    endfunction

    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            rev8[i] = v[7 - i];
    endfunction

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_en_i <= 1'b1;
        @(posedge core_clk_i);
        wr_en_i <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a);
        @(posedge core_clk_i);
        addr_i  <= a;
        rd_en_i <= 1'b1;
        @(posedge core_clk_i);
        rd_en_i <= 1'b0;
        #1 got = rdata_o;
    endtask

    // Waits for the given count of frame ends, then lets the stall run out.
    task automatic wait_rise(input int target);
        int k;
        k = 0;
        while (n_rise < target && k < 4000)
        begin
            @(posedge core_clk_i);
            k++;
        end
        if (n_rise < target)
        begin
            n_mismatch++;
            $display("Error at %0t: transfer did not end", $time);
            finish_test();
        end
        repeat (40) @(posedge core_clk_i);
    endtask

    // Far master for the slave role: chip select frames one byte, half period 8 cycles.
    // A released slave output reads high through the line's pull-up.
    task automatic far_master(input logic [7:0] d);
        m_got = 8'h00;
        @(posedge core_clk_i);
        m_cs_n <= 1'b0;
        m_mosi <= d[7];
        for (int i = 0; i < 8; i++)
        begin
            repeat (8) @(posedge core_clk_i);
            m_sclk <= 1'b1;
            m_got = {m_got[6:0], miso_oe_o ? miso_o : 1'b1};
            repeat (8) @(posedge core_clk_i);
            m_sclk <= 1'b0;
            if (i < 7)
                m_mosi <= d[6 - i];
        end
        repeat (8) @(posedge core_clk_i);
        m_cs_n <= 1'b1;
        repeat (8) @(posedge core_clk_i);
    endtask

    // Polls until the transmit byte has moved into the shifter.
    task automatic wait_loaded;
        int k;
        k = 0;
        got = 16'h0001;
        while (got[0] !== 1'b0 && k < 50)
        begin
            rd(spimsp_pkg::ADDR_STATUS);
            k++;
        end
        if (got[0] !== 1'b0)
            chk(got, 16'h0000);
    endtask

    // Main sequence: reset, register map, mode table, then the awkward cases.
    initial
    begin
        repeat (3) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        rd(spimsp_pkg::ADDR_DIV);
        chk(got, 16'h001B);
        rd(spimsp_pkg::ADDR_RX);
        chk(got, 16'h0000);
        rd(spimsp_pkg::ADDR_CTRL);
        chk(got, 16'h0000);
        wr(spimsp_pkg::ADDR_RX, 16'h00FF);
        rd(spimsp_pkg::ADDR_RX);
        chk(got, 16'h0000);
        rd(spimsp_pkg::ADDR_TX);
        chk(got, 16'h0000);
        rd(32'hFFFF_0A14);
        chk(got, 16'h0000);
        wr(spimsp_pkg::ADDR_DIV, 16'h0007);
        rd(spimsp_pkg::ADDR_DIV);
        chk(got, 16'h0007);
        wr(spimsp_pkg::ADDR_CTRL, 16'hFFFF);
        rd(spimsp_pkg::ADDR_CTRL);
        chk(got, spimsp_pkg::CTRL_MASK);
        for (r0 = 0; r0 < 8; r0++)
        begin
            pol <= ROWS[r0].ctrl[spimsp_pkg::B_CPOL];
            pha <= ROWS[r0].ctrl[spimsp_pkg::B_CPHA];
            wr(spimsp_pkg::ADDR_CTRL, ROWS[r0].ctrl);
            wr(spimsp_pkg::ADDR_TX, {8'h00, ROWS[r0].tx});
            wait_rise(n_rise + 1);
            chk({8'h00, slave_rx}, {8'h00, ROWS[r0].slv});
            rd(spimsp_pkg::ADDR_RX);
            chk(got, {8'h00, ROWS[r0].ctrl[5] ? rev8(~prev) : ~prev});
            prev = ROWS[r0].slv;
            chk({15'h0000, sclk_o}, {15'h0000, pol});
            chk({14'h0000, mosi_oe_o, cs_oe_o}, 16'h0003);
        end
        pol <= 1'b0;
        pha <= 1'b0;
        // Two bytes without reading: continuous and dropping, then single and overwriting.
        for (r0 = 0; r0 < 2; r0++)
        begin
            wr(spimsp_pkg::ADDR_CTRL, 16'h0043 | bitv(r0 ? spimsp_pkg::B_OVWR
                                                     : spimsp_pkg::B_CONT));
            base = n_rise;
            wr(spimsp_pkg::ADDR_TX, 16'h0011);
            wait_loaded();
            wr(spimsp_pkg::ADDR_TX, 16'h0022);
            wait_rise(base + 1 + r0);
            chk({8'h00, slave_rx}, 16'h0022);
            chk(16'(n_rise - base), 16'(r0 + 1));
            rd(spimsp_pkg::ADDR_STATUS);
            chk(got & 16'h0028, 16'h0028);
            rd(spimsp_pkg::ADDR_RX);
            chk(got, {8'h00, r0 ? 8'hEE : ~prev});
            rd(spimsp_pkg::ADDR_STATUS);
            chk(got & 16'h0028, 16'h0000);
            prev = 8'h22;
        end
        // Reads start transfers with the transmit register empty.
        for (r0 = 0; r0 < 2; r0++)
        begin
            wr(spimsp_pkg::ADDR_CTRL, 16'h0003 | (r0 ? bitv(spimsp_pkg::B_UFZERO) : 16'h0000));
            rd(spimsp_pkg::ADDR_RX);
            wait_rise(n_rise + 1);
            chk({8'h00, slave_rx}, r0 ? 16'h0000 : 16'h0022);
            chk({15'h0000, irq_o}, 16'h0001);
            rd(spimsp_pkg::ADDR_STATUS);
            chk(got & 16'h0004, 16'h0004);
        end
        base = n_rise;
        wr(spimsp_pkg::ADDR_TX, 16'h0033);
        repeat (60) @(posedge core_clk_i);
        chk(16'(n_rise - base), 16'h0000);
        rd(spimsp_pkg::ADDR_STATUS);
        chk(got & 16'h0005, 16'h0001);
        // Loopback: the pending byte comes back into the receiver.
        wr(spimsp_pkg::ADDR_CTRL, 16'h0000);
        rd(spimsp_pkg::ADDR_RX);
        wr(spimsp_pkg::ADDR_CTRL, 16'h0843);
        wait_rise(base + 1);
        rd(spimsp_pkg::ADDR_RX);
        chk(got, 16'h0033);
        // Slave role, push-pull then open drain, framed by the bench as far master.
        for (r0 = 0; r0 < 2; r0++)
        begin
            wr(spimsp_pkg::ADDR_CTRL, r0 ? 16'h0401 : 16'h0001);
            wr(spimsp_pkg::ADDR_TX, r0 ? 16'h0096 : 16'h00C3);
            far_master(r0 ? 8'h69 : 8'h5A);
            chk({8'h00, m_got}, r0 ? 16'h0096 : 16'h00C3);
            chk({13'h0000, miso_oe_o, mosi_oe_o, sclk_oe_o}, 16'h0000);
            rd(spimsp_pkg::ADDR_RX);
            chk(got, r0 ? 16'h0069 : 16'h005A);
        end
        // Disabled master keeps still; then chip select output switched off.
        wr(spimsp_pkg::ADDR_CTRL, 16'h004A);
        base = n_rise;
        wr(spimsp_pkg::ADDR_TX, 16'h0044);
        repeat (200) @(posedge core_clk_i);
        chk(16'(n_rise - base), 16'h0000);
        chk({15'h0000, sclk_oe_o}, 16'h0000);
        wr(spimsp_pkg::ADDR_CTRL, 16'h0243);
        repeat (5) @(posedge core_clk_i);
        chk({15'h0000, cs_oe_o}, 16'h0000);
        finish_test();
    end
endmodule
